/* File: logic/crfs_pkg.sv */
// Constants, encodings and carrier types of the clock resource and fallback selector
package crfs_pkg;

   // ************************************************************
   // Register map (word index, byte address is four times it)
   // ************************************************************
   localparam int unsigned ADDR_W          = 8;
   localparam logic [5:0]  IDX_RESOURCE    = 6'h03;
   localparam logic [5:0]  IDX_FALLBACK    = 6'h04;
   localparam logic [5:0]  IDX_STATUS      = 6'h05;
   localparam logic [5:0]  IDX_ERR_FLAGS   = 6'h06;
   localparam logic [7:0]  RESOURCE_RESET  = 8'h00;
   localparam logic [7:0]  FALLBACK_RESET  = 8'h00;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int unsigned RES_SRC_HI      = 7;
   localparam int unsigned RES_SRC_LO      = 6;
   localparam int unsigned RES_P1_BYPASS   = 5;
   localparam int unsigned RES_P1_RATE     = 4;
   localparam int unsigned RES_P2_BYPASS   = 3;
   localparam int unsigned RES_P2_RATE     = 2;
   localparam int unsigned RES_COMPAT_HI   = 1;
   localparam int unsigned RES_COMPAT_LO   = 0;
   localparam int unsigned FB_SRC_HI       = 7;
   localparam int unsigned FB_SRC_LO       = 6;
   localparam int unsigned FB_TYPE_HI      = 5;
   localparam int unsigned FB_TYPE_LO      = 4;
   localparam int unsigned FB_FORCE        = 3;
   localparam int unsigned FB_SYNC_HI      = 2;
   localparam int unsigned FB_SYNC_LO      = 0;
   localparam int unsigned ERR_MAIN        = 0;
   localparam int unsigned ERR_BUS_A       = 1;
   localparam int unsigned ERR_BUS_B       = 2;

   // ************************************************************
   // Rates and multipliers
   // ************************************************************
   localparam int unsigned DIGITAL_PHASE_LOOP_LOW_KHZ    = 2048;
   localparam int unsigned DIGITAL_PHASE_LOOP_HIGH_KHZ   = 4096;
   localparam int unsigned COMPAT_KHZ      = 8192;
   localparam int unsigned P1_MULT_LOW     = 16;
   localparam int unsigned P1_MULT_HIGH    = 32;
   localparam int unsigned P2_MULT_LOW     = 8;
   localparam int unsigned P2_MULT_HIGH    = 16;

   // ************************************************************
   // Bus responses
   // ************************************************************
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   localparam logic [1:0]  RESP_DECERR     = 2'h3;

   // ************************************************************
   // Encodings
   // ************************************************************
   typedef enum logic [1:0] {
      SRC_EXT_PIN   = 2'h0,
      SRC_RES_DIV   = 2'h1,
      SRC_DIGITAL_PHASE_LOOP_LOW  = 2'h2,
      SRC_DIGITAL_PHASE_LOOP_HIGH = 2'h3
   } crfs_src_t;

   typedef enum logic [1:0] {
      FBT_OSC_DIV4  = 2'h0,
      FBT_DISABLED  = 2'h1,
      FBT_SECONDARY = 2'h2,
      FBT_BUS_CLK   = 2'h3
   } crfs_fbtype_t;

   localparam logic [1:0]  COMPAT_8M       = 2'h3;

   // ************************************************************
   // Clock control carrier
   // ************************************************************
   typedef struct packed {
      crfs_src_t  pll1Src;
      logic       pll1Bypass;
      logic       pll1Rate32;
      logic       pll2Bypass;
      logic       pll2Rate16;
      logic       compatClkEn;
      logic       compatDoubleEn;
      logic       syncOverride;
      logic [2:0] syncSel;
      logic       oscDiv4Sel;
      logic       busClkDisable;
      logic       fsmEnable;
      logic       fallbackActive;
   } crfs_ctl_t;

   localparam crfs_ctl_t CTL_RESET = '0;

endpackage

/* File: logic/crfs_top.sv */
// Clock resource and fallback selector with its AXI4-Lite register slave
//
// Overview of operation
// RULE1: Resource bits 7-6 pick loop one input: pin, divider, digital loop 4.096.
// RULE2: Resource source code 10 picks the digital loop at 2.048 MHz.
// RULE3: Alternate source field decodes exactly like the primary source field.
// RULE4: While fallback is in effect, loop one takes the alternate source.
// RULE5: Force bit applies alternate source, fallback type and sync source unconditionally; the code sets syncOverride only for fallback types other than 00.
// RULE6: Resource bit 5 set bypasses loop one, clear runs it normally.
// RULE7: Resource bit 4 sets loop one multiplier: 16 when 0, 32 when 1.
// RULE8: Resource bit 3 set bypasses loop two, clear runs it normally.
// RULE9: Resource bit 2 sets loop two multiplier: 8 when 0, 16 when 1.
// RULE10: Resource bits 1-0 code 11 drive compat clocks at 8.192 MHz, shifted double.
// RULE11: Fallback type field sets the automatic fallback mode on clock failure.
// RULE12: Low fallback field names the sync source used when fallback applies.
// RULE13: Software writes the fallback register last, after other clock registers.
// RULE14: Type 00 oscillator/4, 01 disabled, 10 secondary, 11 bus clocks plus machine.
// RULE15: Fallback holds until error flags are cleared or clocks reprogrammed.
// RULE16: Fallback register bit 3 forces secondary resources, 0 is normal.
// RULE17: Compat codes 00 to 10 are reserved and leave compat outputs inactive.
// RULE18: Both registers read and write; new values reach selectors next clock.
`timescale 1ns/1ps

module crfs_top #(
   parameter int unsigned ADDR_W = crfs_pkg::ADDR_W
) (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
   input  wire logic [2:0]             s_axi_awprot,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [ADDR_W-1:0]      s_axi_araddr,
   input  wire logic [2:0]             s_axi_arprot,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   mainClkFail,
   input  wire logic                   busClkAFail,
   input  wire logic                   busClkBFail,
   output crfs_pkg::crfs_ctl_t         clkCtl
);

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [2:0]          failMeta;
      logic [2:0]          failSync;
      logic                awReady;
      logic                wReady;
      logic                awHeld;
      logic [ADDR_W-1:0]   awAddr;
      logic                wHeld;
      logic [31:0]         wData;
      logic                wLane0;
      logic                bValid;
      logic [1:0]          bResp;
      logic                arReady;
      logic                rValid;
      logic [31:0]         rData;
      logic [1:0]          rResp;
      logic [7:0]          resourceReg;
      logic [7:0]          fallbackReg;
      logic [2:0]          errFlags;
      logic                fbLatched;
      crfs_pkg::crfs_ctl_t ctl;
   } crfs_state_t;

   crfs_state_t state_r;
   crfs_state_t state_nxt;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [5:0] wordIdx(input logic [ADDR_W-1:0] addr);
      wordIdx = 6'(addr[ADDR_W-1:2]);
   endfunction

   // Same decode for primary and alternate fields
   function automatic crfs_pkg::crfs_src_t decodeSrc(input logic [1:0] code);
      decodeSrc = crfs_pkg::crfs_src_t'(code); // see RULE1 see RULE2 see RULE3
   endfunction

   // Failures that trigger fallback in each mode
   function automatic logic [2:0] failMask(input crfs_pkg::crfs_fbtype_t fbType);
      case (fbType)
         crfs_pkg::FBT_OSC_DIV4:  failMask = 3'h1; // see RULE14
         crfs_pkg::FBT_SECONDARY: failMask = 3'h1; // see RULE14
         crfs_pkg::FBT_BUS_CLK:   failMask = 3'h6; // see RULE14
         default:                 failMask = 3'h0; // see RULE14
      endcase
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic [2:0]             clrMask;
      logic                   reprog;
      logic [2:0]             trig;
      logic                   active;
      crfs_pkg::crfs_fbtype_t fbType;
      clrMask   = 3'h0;
      reprog    = 1'b0;
      trig      = 3'h0;
      active    = 1'b0;
      fbType    = crfs_pkg::FBT_OSC_DIV4;
      state_nxt = state_r;

      // Failure inputs synchronised
      state_nxt.failMeta = {busClkBFail, busClkAFail, mainClkFail};
      state_nxt.failSync = state_r.failMeta;

      // Write channels
      if (s_axi_awvalid && state_r.awReady) begin
         state_nxt.awHeld = 1'b1;
         state_nxt.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && state_r.wReady) begin
         state_nxt.wHeld  = 1'b1;
         state_nxt.wData  = s_axi_wdata;
         state_nxt.wLane0 = s_axi_wstrb[0];
      end
      if (state_r.bValid && s_axi_bready) begin
         state_nxt.bValid = 1'b0;
      end
      if (state_r.awHeld && state_r.wHeld && !state_r.bValid) begin
         state_nxt.awHeld = 1'b0;
         state_nxt.wHeld  = 1'b0;
         state_nxt.bValid = 1'b1;
         state_nxt.bResp  = crfs_pkg::RESP_OKAY;
         case (wordIdx(state_r.awAddr))
            crfs_pkg::IDX_RESOURCE: begin
               if (state_r.wLane0) begin
                  state_nxt.resourceReg = state_r.wData[7:0]; // see RULE18
                  reprog = 1'b1;
               end
            end
            crfs_pkg::IDX_FALLBACK: begin
               if (state_r.wLane0) begin
                  state_nxt.fallbackReg = state_r.wData[7:0]; // see RULE18
                  reprog = 1'b1;
               end
            end
            crfs_pkg::IDX_ERR_FLAGS: begin
               if (state_r.wLane0) begin
                  clrMask = state_r.wData[2:0];
               end
            end
            crfs_pkg::IDX_STATUS: begin
               state_nxt.bResp = crfs_pkg::RESP_SLVERR;
            end
            default: begin
               state_nxt.bResp = crfs_pkg::RESP_DECERR;
            end
         endcase
      end

      // Sticky error flags, set wins over clear
      fbType = crfs_pkg::crfs_fbtype_t'(
         state_r.fallbackReg[crfs_pkg::FB_TYPE_HI:crfs_pkg::FB_TYPE_LO]);
      trig = state_r.failSync & failMask(fbType); // see RULE11
      state_nxt.errFlags = (state_r.errFlags & ~clrMask) | state_r.failSync;
      state_nxt.fbLatched = (state_r.fbLatched & ~(reprog | (|clrMask))) | (|trig); // see RULE15

      // Clock control outputs
      active = state_r.fbLatched | state_r.fallbackReg[crfs_pkg::FB_FORCE]; // see RULE5 see RULE16
      state_nxt.ctl.fallbackActive = active;
      if (active) begin
         state_nxt.ctl.pll1Src = decodeSrc(
            state_r.fallbackReg[crfs_pkg::FB_SRC_HI:crfs_pkg::FB_SRC_LO]); // see RULE4
      end else begin
         state_nxt.ctl.pll1Src = decodeSrc(
            state_r.resourceReg[crfs_pkg::RES_SRC_HI:crfs_pkg::RES_SRC_LO]); // see RULE1
      end
      state_nxt.ctl.pll1Bypass = state_r.resourceReg[crfs_pkg::RES_P1_BYPASS]; // see RULE6
      state_nxt.ctl.pll1Rate32 = state_r.resourceReg[crfs_pkg::RES_P1_RATE]; // see RULE7
      state_nxt.ctl.pll2Bypass = state_r.resourceReg[crfs_pkg::RES_P2_BYPASS]; // see RULE8
      state_nxt.ctl.pll2Rate16 = state_r.resourceReg[crfs_pkg::RES_P2_RATE]; // see RULE9
      state_nxt.ctl.compatClkEn = (state_r.resourceReg[crfs_pkg::RES_COMPAT_HI:
         crfs_pkg::RES_COMPAT_LO] == crfs_pkg::COMPAT_8M); // see RULE10 see RULE17
      state_nxt.ctl.compatDoubleEn = state_nxt.ctl.compatClkEn; // see RULE10
      state_nxt.ctl.syncOverride = active && (fbType != crfs_pkg::FBT_OSC_DIV4); // see RULE12
      state_nxt.ctl.syncSel = state_r.fallbackReg[crfs_pkg::FB_SYNC_HI:crfs_pkg::FB_SYNC_LO];
      state_nxt.ctl.oscDiv4Sel = active && (fbType == crfs_pkg::FBT_OSC_DIV4); // see RULE14
      state_nxt.ctl.busClkDisable = active && (fbType == crfs_pkg::FBT_BUS_CLK); // see RULE14
      state_nxt.ctl.fsmEnable = (fbType == crfs_pkg::FBT_BUS_CLK); // see RULE14

      // Read channel
      if (state_r.rValid && s_axi_rready) begin
         state_nxt.rValid = 1'b0;
      end
      if (s_axi_arvalid && state_r.arReady) begin
         state_nxt.rValid = 1'b1;
         state_nxt.rData  = 32'h0000_0000;
         state_nxt.rResp  = crfs_pkg::RESP_OKAY;
         case (wordIdx(s_axi_araddr))
            crfs_pkg::IDX_RESOURCE:  state_nxt.rData[7:0] = state_r.resourceReg; // see RULE18
            crfs_pkg::IDX_FALLBACK:  state_nxt.rData[7:0] = state_r.fallbackReg; // see RULE18
            crfs_pkg::IDX_STATUS:    state_nxt.rData[15:0] = 16'(state_r.ctl);
            crfs_pkg::IDX_ERR_FLAGS: state_nxt.rData[3:0] = {state_r.fbLatched, state_r.errFlags};
            default:                 state_nxt.rResp = crfs_pkg::RESP_DECERR;
         endcase
      end

      state_nxt.awReady = !state_nxt.awHeld && !state_nxt.bValid;
      state_nxt.wReady  = !state_nxt.wHeld && !state_nxt.bValid;
      state_nxt.arReady = !state_nxt.rValid;
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r             <= '0;
         state_r.resourceReg <= crfs_pkg::RESOURCE_RESET;
         state_r.fallbackReg <= crfs_pkg::FALLBACK_RESET;
         state_r.ctl         <= crfs_pkg::CTL_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign s_axi_awready = state_r.awReady;
   assign s_axi_wready  = state_r.wReady;
   assign s_axi_bvalid  = state_r.bValid;
   assign s_axi_bresp   = state_r.bResp;
   assign s_axi_arready = state_r.arReady;
   assign s_axi_rvalid  = state_r.rValid;
   assign s_axi_rdata   = state_r.rData;
   assign s_axi_rresp   = state_r.rResp;
   assign clkCtl        = state_r.ctl;

endmodule

/* File: verif/crfs_chk.sv */
// Port checker for the clock resource and fallback selector
`timescale 1ns/1ps
module crfs_chk #(
   parameter int unsigned ADDR_W = crfs_pkg::ADDR_W
) (
   input wire logic                clock,
   input wire logic                rst_n,
   input wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic [31:0]         s_axi_wdata,
   input wire logic [3:0]          s_axi_wstrb,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic [1:0]          s_axi_bresp,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic [ADDR_W-1:0]   s_axi_araddr,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic [1:0]          s_axi_rresp,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input crfs_pkg::crfs_ctl_t      clkCtl
);
   // ************************************************************
   // Assertions
   // ************************************************************
   logic wrRes;
   assign wrRes = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                  && s_axi_awaddr == 8'h0C && s_axi_wstrb[0];
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   write_held_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
   read_held_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read response dropped early");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
   unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
      !(s_axi_araddr inside {8'h0C, 8'h10, 8'h14, 8'h18}) |=>
      s_axi_rresp == crfs_pkg::RESP_DECERR && s_axi_rdata == 32'h00000000)
      else $error("unmapped read not refused");
   write_block_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken while response pending");
   loop_bits_a: assert property (wrRes |-> ##3
      {clkCtl.pll1Bypass, clkCtl.pll1Rate32, clkCtl.pll2Bypass, clkCtl.pll2Rate16}
      == $past(s_axi_wdata[5:2], 3)) else $error("loop control bits wrong");
   compat_code_a: assert property (wrRes |-> ##3
      clkCtl.compatClkEn == ($past(s_axi_wdata[1:0], 3) == 2'h3))
      else $error("compat clock decode wrong");
   src_select_a: assert property (wrRes |-> ##3 clkCtl.fallbackActive ||
      clkCtl.pll1Src == $past(s_axi_wdata[7:6], 3)) else $error("loop source wrong");
   compat_pair_a: assert property (clkCtl.compatClkEn == clkCtl.compatDoubleEn)
      else $error("compat clocks disagree");
   fb_modes_a: assert property (clkCtl.oscDiv4Sel || clkCtl.busClkDisable
      || clkCtl.syncOverride |-> clkCtl.fallbackActive) else $error("fallback mode idle");
   bus_disable_a: assert property (clkCtl.busClkDisable |->
      clkCtl.fsmEnable && !clkCtl.oscDiv4Sel) else $error("bus fallback mode wrong");
endmodule
bind crfs_top crfs_chk #(.ADDR_W(ADDR_W)) crfs_chk_inst (.*);

/* File: verif/tb_top.sv */
// Self-checking bench for the clock resource and fallback selector
`timescale 1ns/1ps
module tb_top;
   // ************************************************************
   // Signals and tasks
   // ************************************************************
   logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic s_axi_rready, mainClkFail, busClkAFail, busClkBFail;
   logic [7:0]           s_axi_awaddr, s_axi_araddr;
   logic [2:0]           s_axi_awprot, s_axi_arprot;
   logic [31:0]          s_axi_wdata, s_axi_rdata;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp;
   crfs_pkg::crfs_ctl_t  clkCtl;
   int                   errors, num_checks;
   int                   holdOff;
   crfs_top crfs_top_inst (.*);
   task automatic stop_test;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic da, dw, tb;
      logic [1:0] rs;
      da = 1'b0;
      dw = 1'b0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(da && dw)) begin
         @(negedge clock);
         da = da | s_axi_awready;
         dw = dw | s_axi_wready;
         @(posedge clock);
         s_axi_awvalid <= !da;
         s_axi_wvalid <= !dw;
      end
      repeat (holdOff) @(posedge clock);
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clock);
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge clock);
      end while (!tb);
      s_axi_bready <= 1'b0;
      chk(rs, er);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
      logic t;
      logic [31:0] d;
      logic [1:0] rs;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(negedge clock);
         t = s_axi_arready;
         @(posedge clock);
      end while (!t);
      s_axi_arvalid <= 1'b0;
      repeat (holdOff) @(posedge clock);
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clock);
         t = s_axi_rvalid;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge clock);
      end while (!t);
      s_axi_rready <= 1'b0;
      chk(d, {24'h000000, ed});
      chk(rs, er);
   endtask
   task automatic t_reset;
      rdchk(8'h0C, 8'h00, crfs_pkg::RESP_OKAY);
      rdchk(8'h10, 8'h00, crfs_pkg::RESP_OKAY);
      rdchk(8'h20, 8'h00, crfs_pkg::RESP_DECERR);
      wr(8'h20, 8'h55, crfs_pkg::RESP_DECERR);
      wr(8'h14, 8'h11, crfs_pkg::RESP_SLVERR);
   endtask
   task automatic t_resource;
      logic [7:0] v;
      for (int i = 0; i < 4; i++) begin
         v = 8'(8'h55 * i);
         wr(8'h0C, v, crfs_pkg::RESP_OKAY);
         repeat (2) @(negedge clock);
         chk(clkCtl[15:8],
            {v[7:2], {2{v[1:0] == 2'h3}}});
         rdchk(8'h0C, v, crfs_pkg::RESP_OKAY);
      end
   endtask
   task automatic t_stall;
      holdOff = 3;
      s_axi_wstrb <= 4'hE;
      wr(8'h0C, 8'h00, crfs_pkg::RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      rdchk(8'h0C, 8'hFF, crfs_pkg::RESP_OKAY);
      holdOff = 0;
   endtask
   task automatic t_force;
      logic [7:0] v;
      wr(8'h0C, 8'h40, crfs_pkg::RESP_OKAY);
      for (int t = 0; t < 4; t++) begin
         v = {2'h3, t[1:0], 1'b1, 3'h5};
         wr(8'h10, v, crfs_pkg::RESP_OKAY);
         repeat (2) @(negedge clock);
         chk({clkCtl.pll1Src, clkCtl.syncOverride,
            clkCtl.syncSel, clkCtl.oscDiv4Sel, clkCtl.busClkDisable, clkCtl.fsmEnable,
            clkCtl.fallbackActive}, {2'h3, t != 0, 3'h5, t == 0, t == 3, t == 3, 1'b1});
      end
      wr(8'h10, 8'hE5, crfs_pkg::RESP_OKAY);
      repeat (2) @(negedge clock);
      chk({clkCtl.pll1Src, clkCtl.fallbackActive, clkCtl.syncOverride}, 4'h4);
   endtask
   task automatic t_fail(input logic [7:0] fb, input logic busA, input logic act,
                         input logic [7:0] fl);
      wr(8'h10, fb, crfs_pkg::RESP_OKAY);
      mainClkFail <= !busA;
      busClkAFail <= busA;
      repeat (6) @(posedge clock);
      mainClkFail <= 1'b0;
      busClkAFail <= 1'b0;
      repeat (6) @(negedge clock);
      chk({clkCtl.fallbackActive, clkCtl.pll1Src}, {act, act ? 2'h2 : 2'h1});
      rdchk(8'h18, fl, crfs_pkg::RESP_OKAY);
      wr(8'h18, 8'h07, crfs_pkg::RESP_OKAY);
      repeat (2) @(negedge clock);
      chk(clkCtl.fallbackActive, 1'b0);
   endtask
   // ************************************************************
   // Run
   // ************************************************************
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {mainClkFail, busClkAFail, busClkBFail, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      holdOff = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_reset;
      t_resource;
      t_stall;
      t_force;
      t_fail(8'h82, 1'b0, 1'b1, 8'h09);
      t_fail(8'h92, 1'b0, 1'b0, 8'h01);
      t_fail(8'hA2, 1'b0, 1'b1, 8'h09);
      t_fail(8'hB2, 1'b1, 1'b1, 8'h0A);
      stop_test;
   end
   initial begin
      #100000;
      errors++;
      stop_test;
   end
endmodule
